/* rtl/eicr_regs.sv */
// Input configuration register bank of a TV encoder, offsets 14h to 20h.
// Assumes a serial port front end that presents single-cycle read and
// write strobes with an address and data, all on i_clk.
//
// Summary of operation
// RULE1 - Mode bit clear selects SD modes 37/38, set selects component modes.
// RULE2 - Input clock rate bit: 0 pixel rate dual edge, 1 double rate single edge.
// RULE3 - Output clock rate bit: 0 pixel frequency, 1 twice pixel frequency.
// RULE4 - Clock invert bit inverts incoming pixel clock so the other edge latches.
// RULE5 - Master uses crystal reference and dividers; slave uses pixel clock, dividers one.
// RULE6 - Delay field: top bit ahead or behind, low three bits count 70 ps steps.
// RULE7 - Black level update in vertical blanking happens only while enabled.
// RULE8 - Output clock polarity bit inverts the pixel clock output when set.
// RULE9 - Output clock enable bit drives the pixel clock pin when set.
// RULE10 - Output pins drive level bits; input pins read back the pin level.
// RULE11 - Direction bit 1 makes pin an input, 0 a non-inverting output.
// RULE12 - After reset both pins are pulled-up inputs, level bits read 1.
// RULE13 - Three-bit format field selects how the 12-bit input bus is read.
// RULE14 - Format codes 0 to 3 are RGB, code 4 is YCrCb.
// RULE15 - Horizontal sync polarity: 0 active low, 1 active high.
// RULE16 - Vertical sync polarity: 0 active low, 1 active high.
// RULE17 - Sync direction 0 makes sync pins inputs, 1 makes the device drive them.
// RULE18 - Embedded sync used only when selected and format 4; else sync pins.
// RULE19 - Buffer select: 0 single-ended receivers, 1 differential clock and comparators.
// RULE20 - Host enables all DACs, sets then clears sense before reading status.
// RULE21 - While sense is set DACs hold constant and no sync pulses go out.
// RULE22 - On sense clear, unconnected outputs read 0, connected outputs read 1.
// RULE23 - Connection detect bit 6 is the crystal oscillator gain MSB.
// RULE24 - Status latches at the sense fall and holds until the next sequence.
`timescale 1ns/1ns
`default_nettype none

module eicr_regs
  import eicr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port from the serial front end.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Pins and internal sources.
  input wire logic [1:0] i_gpio_pin,
  input wire logic i_hsync_pin,
  input wire logic i_vsync_pin,
  input wire logic i_int_hsync,
  input wire logic i_int_vsync,
  input wire logic i_embedded_hsync,
  input wire logic i_embedded_vsync,
  input wire logic i_vblank_update,
  input wire logic [DAC_COUNT-1:0] i_dac_connected,
  // Control outputs.
  output logic o_hd_mode_select,
  output logic o_bandgap_boost,
  output logic o_in_clock_rate_sel,
  output logic o_dual_edge_capture,
  output logic o_clk_out_rate_sel,
  output logic o_in_clock_invert,
  output logic o_pll_master,
  output logic o_pll_div_force_one,
  output logic o_clock_delay_behind,
  output logic [2:0] o_clock_delay_steps,
  output logic o_black_level_load,
  output logic o_clk_out_polarity,
  output logic o_clk_out_enable,
  output logic [1:0] o_gpio_out,
  output logic [1:0] o_gpio_oe,
  output logic [2:0] o_input_format_sel,
  output logic o_format_is_rgb,
  output logic o_format_is_ycrcb,
  output logic o_hsync_out,
  output logic o_hsync_oe,
  output logic o_vsync_out,
  output logic o_vsync_oe,
  output logic o_hsync_active,
  output logic o_vsync_active,
  output logic o_sync_from_embedded,
  output logic o_input_buffer_type,
  output logic o_dac_hold_constant,
  output logic o_tv_sync_suppress,
  output logic o_crystal_osc_gain_msb
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tv_standard_reg;
    logic [7:0] clock_mode_reg;
    logic [7:0] input_clock_delay_reg;
    logic [7:0] pin_control_reg;
    logic [7:0] input_format_reg;
    logic [7:0] connection_detect_reg;
    logic [7:0] rdata;
    logic rvalid;
    logic black_level_load;
    logic [1:0] gpio_out;
    logic [1:0] gpio_oe;
    logic hsync_out;
    logic hsync_oe;
    logic vsync_out;
    logic vsync_oe;
    logic hsync_active;
    logic vsync_active;
    logic sync_from_embedded;
  } eicr_regs_state_t;

  eicr_regs_state_t state;
  eicr_regs_state_t next_state;

  logic [1:0] gpio_sync;
  logic [1:0] sync_pins;
  logic [DAC_COUNT-1:0] dac_sync;
  logic [DAC_COUNT-1:0] load_status;

  // ----------------------------------------------------------------
  // Crossings and load sense
  // ----------------------------------------------------------------

  // Pins and comparator outputs pass two flip-flops before any logic.
  eicr_sync #(
    .WIDTH(4 + DAC_COUNT)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_gpio_pin, i_hsync_pin, i_vsync_pin, i_dac_connected}),
    .o_sync({gpio_sync, sync_pins, dac_sync})
  );

  // Status capture at the end of a sensing sequence.
  eicr_detect #(
    .DACS(DAC_COUNT)
  ) u_detect (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_sense(state.connection_detect_reg[SENSE_BIT]),
    .i_dac_connected(dac_sync),
    .o_status(load_status)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Register writes, read mux and the pin and sync paths.
  always_comb begin
    logic sense;
    logic fmt_ycrcb;
    logic hpol;
    logic vpol;
    logic [1:0] dir_in;
    logic [1:0] level_rd;
    sense = state.connection_detect_reg[SENSE_BIT];
    fmt_ycrcb = (state.input_format_reg[INPUT_FORMAT_SEL_LSB +: 3] == FORMAT_YCRCB);
    hpol = state.input_format_reg[HSYNC_POLARITY_BIT];
    vpol = state.input_format_reg[VSYNC_POLARITY_BIT];
    dir_in = state.pin_control_reg[PIN_DIR_INPUT_LSB +: 2];
    level_rd = 2'h0;
    next_state = state;

    // Writes store whole bytes except the read-only status bits.
    if (i_reg_wr) begin
      case (i_reg_addr)
        TV_STANDARD_OFS: begin
          next_state.tv_standard_reg = i_reg_wdata;
        end
        CLOCK_MODE_OFS: begin
          next_state.clock_mode_reg = i_reg_wdata;
        end
        INPUT_CLOCK_DELAY_OFS: begin
          next_state.input_clock_delay_reg = i_reg_wdata;
        end
        PIN_CONTROL_OFS: begin
          next_state.pin_control_reg = i_reg_wdata;
        end
        INPUT_FORMAT_OFS: begin
          next_state.input_format_reg = i_reg_wdata;
        end
        CONNECTION_DETECT_OFS: begin
          next_state.connection_detect_reg = i_reg_wdata & CONNECTION_DETECT_WMASK;
        end
        default: begin
          next_state.rvalid = state.rvalid;
        end
      endcase
    end

    // Level bits of input pins read the synchronised pin level.
    for (int i = 0; i < 2; i++) begin
      level_rd[i] = dir_in[i] ? gpio_sync[i] : state.pin_control_reg[PIN_LEVEL_LSB + i]; // [RULE10]
    end

    // Reads answer one cycle after the strobe; unmapped offsets read zero.
    next_state.rvalid = i_reg_rd;
    if (i_reg_rd) begin
      case (i_reg_addr)
        TV_STANDARD_OFS: begin
          next_state.rdata = state.tv_standard_reg;
        end
        CLOCK_MODE_OFS: begin
          next_state.rdata = state.clock_mode_reg;
        end
        INPUT_CLOCK_DELAY_OFS: begin
          next_state.rdata = state.input_clock_delay_reg;
        end
        PIN_CONTROL_OFS: begin
          next_state.rdata = {state.pin_control_reg[7:6], level_rd,
                              state.pin_control_reg[3:0]}; // [RULE10] [RULE12]
        end
        INPUT_FORMAT_OFS: begin
          next_state.rdata = state.input_format_reg;
        end
        CONNECTION_DETECT_OFS: begin
          next_state.rdata = {state.connection_detect_reg[7:5], load_status,
                              state.connection_detect_reg[SENSE_BIT]}; // [RULE22]
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end

    // Black level load passes only while its enable is set.
    next_state.black_level_load = i_vblank_update &
      state.input_clock_delay_reg[BLACK_LEVEL_UPDATE_EN_BIT]; // [RULE7]

    // Output pins drive their level bit without inversion.
    next_state.gpio_out = state.pin_control_reg[PIN_LEVEL_LSB +: 2]; // [RULE10]
    next_state.gpio_oe = ~dir_in; // [RULE11]

    // Driven sync goes out at the programmed polarity, idle while sensing.
    next_state.hsync_oe = state.input_format_reg[SYNC_DIRECTION_BIT]; // [RULE17]
    next_state.vsync_oe = state.input_format_reg[SYNC_DIRECTION_BIT]; // [RULE17]
    next_state.hsync_out = ~((i_int_hsync & ~sense) ^ hpol); // [RULE15] [RULE21]
    next_state.vsync_out = ~((i_int_vsync & ~sense) ^ vpol); // [RULE16] [RULE21]

    // Sync source: embedded codes only for YCrCb with the select bit set.
    next_state.sync_from_embedded = state.input_format_reg[EMBEDDED_SYNC_BIT] &
      fmt_ycrcb; // [RULE18]
    if (state.input_format_reg[SYNC_DIRECTION_BIT]) begin
      next_state.hsync_active = i_int_hsync & ~sense;
      next_state.vsync_active = i_int_vsync & ~sense;
    end else if (state.input_format_reg[EMBEDDED_SYNC_BIT] && fmt_ycrcb) begin
      next_state.hsync_active = i_embedded_hsync; // [RULE18]
      next_state.vsync_active = i_embedded_vsync; // [RULE18]
    end else begin
      next_state.hsync_active = ~(sync_pins[1] ^ hpol); // [RULE15]
      next_state.vsync_active = ~(sync_pins[0] ^ vpol); // [RULE16]
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset loads the register defaults; pins come up as pulled-up inputs.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
      state.tv_standard_reg <= TV_STANDARD_RST;
      state.clock_mode_reg <= CLOCK_MODE_RST;
      state.input_clock_delay_reg <= INPUT_CLOCK_DELAY_RST;
      state.pin_control_reg <= PIN_CONTROL_RST; // [RULE12]
      state.input_format_reg <= INPUT_FORMAT_RST;
      state.connection_detect_reg <= CONNECTION_DETECT_RST;
      state.gpio_out <= 2'h3;
      state.hsync_out <= 1'b1;
      state.vsync_out <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Register port answer.
  assign o_reg_rdata = state.rdata;
  assign o_reg_rvalid = state.rvalid;

  // Standard and clocking controls straight from register bits.
  assign o_hd_mode_select = state.tv_standard_reg[HD_MODE_SELECT_BIT]; // [RULE1]
  assign o_bandgap_boost = state.tv_standard_reg[BANDGAP_BOOST_BIT];
  assign o_in_clock_rate_sel = state.clock_mode_reg[IN_CLOCK_RATE_SEL_BIT]; // [RULE2]
  assign o_dual_edge_capture = ~state.clock_mode_reg[IN_CLOCK_RATE_SEL_BIT]; // [RULE2]
  assign o_clk_out_rate_sel = state.clock_mode_reg[CLK_OUT_RATE_BIT]; // [RULE3]
  assign o_in_clock_invert = state.clock_mode_reg[IN_CLOCK_INVERT_BIT]; // [RULE4]
  assign o_pll_master = state.clock_mode_reg[PLL_MASTER_BIT]; // [RULE5]
  assign o_pll_div_force_one = ~state.clock_mode_reg[PLL_MASTER_BIT]; // [RULE5]
  assign o_clock_delay_behind = state.input_clock_delay_reg[CLOCK_DELAY_BEHIND_BIT]; // [RULE6]
  assign o_clock_delay_steps = state.input_clock_delay_reg[CLOCK_DELAY_STEPS_LSB +: 3]; // [RULE6]
  assign o_black_level_load = state.black_level_load;
  assign o_clk_out_polarity = state.pin_control_reg[CLK_OUT_POLARITY_BIT]; // [RULE8]
  assign o_clk_out_enable = state.pin_control_reg[CLK_OUT_ENABLE_BIT]; // [RULE9]

  // General-purpose and sync pins.
  assign o_gpio_out = state.gpio_out;
  assign o_gpio_oe = state.gpio_oe;
  assign o_hsync_out = state.hsync_out;
  assign o_hsync_oe = state.hsync_oe;
  assign o_vsync_out = state.vsync_out;
  assign o_vsync_oe = state.vsync_oe;
  assign o_hsync_active = state.hsync_active;
  assign o_vsync_active = state.vsync_active;
  assign o_sync_from_embedded = state.sync_from_embedded;

  // Input format decode and receiver type.
  assign o_input_format_sel = state.input_format_reg[INPUT_FORMAT_SEL_LSB +: 3]; // [RULE13]
  assign o_format_is_rgb = (state.input_format_reg[INPUT_FORMAT_SEL_LSB +: 3] <=
                            FORMAT_RGB_LAST); // [RULE14]
  assign o_format_is_ycrcb = (state.input_format_reg[INPUT_FORMAT_SEL_LSB +: 3] ==
                              FORMAT_YCRCB); // [RULE14]
  assign o_input_buffer_type = state.input_format_reg[INPUT_BUFFER_TYPE_BIT]; // [RULE19]

  // Load sense holds the DACs steady and mutes sync.
  assign o_dac_hold_constant = state.connection_detect_reg[SENSE_BIT]; // [RULE21]
  assign o_tv_sync_suppress = state.connection_detect_reg[SENSE_BIT]; // [RULE21]
  assign o_crystal_osc_gain_msb =
    state.connection_detect_reg[CRYSTAL_OSC_GAIN_MSB_BIT]; // [RULE23]

endmodule : eicr_regs

`default_nettype wire

/* rtl/eicr_pkg.sv */
// Package for the encoder input configuration register bank.
// Holds register offsets, reset values, field positions and format codes.
// Assumes all users import the whole package.
package eicr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TV_STANDARD_OFS = 8'h14;
  localparam logic [7:0] CLOCK_MODE_OFS = 8'h1c;
  localparam logic [7:0] INPUT_CLOCK_DELAY_OFS = 8'h1d;
  localparam logic [7:0] PIN_CONTROL_OFS = 8'h1e;
  localparam logic [7:0] INPUT_FORMAT_OFS = 8'h1f;
  localparam logic [7:0] CONNECTION_DETECT_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TV_STANDARD_RST = 8'h02;
  localparam logic [7:0] CLOCK_MODE_RST = 8'h00;
  localparam logic [7:0] INPUT_CLOCK_DELAY_RST = 8'h48;
  localparam logic [7:0] PIN_CONTROL_RST = 8'hf2;
  localparam logic [7:0] INPUT_FORMAT_RST = 8'ha4;
  localparam logic [7:0] CONNECTION_DETECT_RST = 8'h40;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HD_MODE_SELECT_BIT = 0;
  localparam int BANDGAP_BOOST_BIT = 7;
  localparam int IN_CLOCK_RATE_SEL_BIT = 0;
  localparam int CLK_OUT_RATE_BIT = 1;
  localparam int IN_CLOCK_INVERT_BIT = 2;
  localparam int PLL_MASTER_BIT = 3;
  localparam int CLOCK_DELAY_BEHIND_BIT = 3;
  localparam int CLOCK_DELAY_STEPS_LSB = 0;
  localparam int BLACK_LEVEL_UPDATE_EN_BIT = 6;
  localparam int CLK_OUT_POLARITY_BIT = 0;
  localparam int CLK_OUT_ENABLE_BIT = 1;
  localparam int PIN_LEVEL_LSB = 4;
  localparam int PIN_DIR_INPUT_LSB = 6;
  localparam int INPUT_FORMAT_SEL_LSB = 0;
  localparam int HSYNC_POLARITY_BIT = 3;
  localparam int VSYNC_POLARITY_BIT = 4;
  localparam int SYNC_DIRECTION_BIT = 5;
  localparam int EMBEDDED_SYNC_BIT = 6;
  localparam int INPUT_BUFFER_TYPE_BIT = 7;
  localparam int SENSE_BIT = 0;
  localparam int OUTPUT_LOAD_STATUS_LSB = 1;
  localparam int CRYSTAL_OSC_GAIN_MSB_BIT = 6;

  // Writable bits of the connection detect register; status bits are read only.
  localparam logic [7:0] CONNECTION_DETECT_WMASK = 8'he1;

  // ----------------------------------------------------------------
  // Format codes and analog figures
  // ----------------------------------------------------------------
  localparam logic [2:0] FORMAT_RGB_LAST = 3'h3;
  localparam logic [2:0] FORMAT_YCRCB = 3'h4;
  localparam int CLOCK_DELAY_STEP_PS = 70;
  localparam int DAC_COUNT = 4;

endpackage : eicr_pkg

/* rtl/eicr_sync.sv */
// Two-stage synchroniser for levels that arrive from outside the clock domain.
// Assumes the inputs are slow levels; pulses shorter than one clock period may be lost.
`timescale 1ns/1ns
`default_nettype none

module eicr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } eicr_sync_state_t;

  eicr_sync_state_t state;
  eicr_sync_state_t next_state;

  // Only the second stage reads the first one.
  always_comb begin
    next_state = state;
    next_state.stage1 = i_async;
    next_state.stage2 = state.stage1;
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.stage2;

endmodule : eicr_sync

`default_nettype wire

/* rtl/eicr_detect.sv */
// Load-sense capture for the DAC outputs.
// Assumes the comparator results are already synchronised to i_clk.
`timescale 1ns/1ns
`default_nettype none

module eicr_detect
  import eicr_pkg::*;
#(
  parameter int DACS = DAC_COUNT
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sense,
  input wire logic [DACS-1:0] i_dac_connected,
  output logic [DACS-1:0] o_status
);

  typedef struct packed {
    logic sense_d;
    logic [DACS-1:0] status;
  } eicr_detect_state_t;

  eicr_detect_state_t state;
  eicr_detect_state_t next_state;

  // On the falling edge of sense each status bit takes its comparison,
  // so unconnected outputs read 0 and connected ones 1 until the next falling edge of sense.
  always_comb begin
    next_state = state;
    next_state.sense_d = i_sense;
    if (state.sense_d && !i_sense) begin
      next_state.status = i_dac_connected; // [RULE22] [RULE24]
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_status = state.status;

endmodule : eicr_detect

`default_nettype wire

/* testbench/eicr_regs_monitor.sv */
// Concurrent checks on the ports of the input configuration register bank.
// Assumes one clock domain with an active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module eicr_regs_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_vblank_update,
  input wire logic o_in_clock_rate_sel,
  input wire logic o_dual_edge_capture,
  input wire logic o_pll_master,
  input wire logic o_pll_div_force_one,
  input wire logic o_black_level_load,
  input wire logic [2:0] o_input_format_sel,
  input wire logic o_format_is_rgb,
  input wire logic o_format_is_ycrcb,
  input wire logic o_sync_from_embedded,
  input wire logic o_dac_hold_constant,
  input wire logic o_tv_sync_suppress,
  input wire logic o_hsync_oe,
  input wire logic o_vsync_oe
);
  // All checks share the register clock and reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  property p_dual_edge;
    o_dual_edge_capture == !o_in_clock_rate_sel;
  endproperty
  a_dual_edge: assert property (p_dual_edge) else $error("capture mode mismatch");
  property p_div_force;
    o_pll_div_force_one != o_pll_master;
  endproperty
  a_div_force: assert property (p_div_force) else $error("divider force mismatch");
  property p_black_idle;
    !i_vblank_update |=> !o_black_level_load;
  endproperty
  a_black_idle: assert property (p_black_idle) else $error("unrequested load");
  property p_rgb;
    o_format_is_rgb == (o_input_format_sel <= 3'h3);
  endproperty
  a_rgb: assert property (p_rgb) else $error("rgb decode wrong");
  property p_ycrcb;
    o_format_is_ycrcb == (o_input_format_sel == 3'h4);
  endproperty
  a_ycrcb: assert property (p_ycrcb) else $error("ycrcb decode wrong");
  property p_embedded;
    o_sync_from_embedded |-> $past(o_input_format_sel) == 3'h4;
  endproperty
  a_embedded: assert property (p_embedded) else $error("embedded sync off format");
  property p_sense;
    o_dac_hold_constant == o_tv_sync_suppress;
  endproperty
  a_sense: assert property (p_sense) else $error("sense outputs disagree");
  property p_sync_oe;
    o_hsync_oe == o_vsync_oe;
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync directions disagree");
  c_load: cover property (i_vblank_update ##1 o_black_level_load);
  c_embedded: cover property ($rose(o_sync_from_embedded));
  c_sense: cover property ($fell(o_dac_hold_constant));
endmodule : eicr_regs_monitor
bind eicr_regs eicr_regs_monitor u_eicr_regs_monitor (.*);
`default_nettype wire

/* testbench/eicr_video_source.sv */
// Far-side model: video source sync pins, pulled-up pins and DAC loads.
// Assumes the bench sets the forced levels and the load pattern.
`timescale 1ns/1ns
`default_nettype none
module eicr_video_source (
  input wire logic [1:0] i_gpio_out,
  input wire logic [1:0] i_gpio_oe,
  input wire logic [1:0] i_force_low,
  input wire logic i_hsync_out,
  input wire logic i_hsync_oe,
  input wire logic i_vsync_out,
  input wire logic i_vsync_oe,
  input wire logic i_src_hsync,
  input wire logic i_src_vsync,
  input wire logic [3:0] i_loads,
  output logic [1:0] o_gpio_pin,
  output logic o_hsync_pin,
  output logic o_vsync_pin,
  output logic [3:0] o_dac_connected
);
  // Undriven pins rise through the pull-up unless forced low.
  assign o_gpio_pin = (i_gpio_oe & i_gpio_out) | (~i_gpio_oe & ~i_force_low);
  // The source drives sync only while the device leaves the pins as inputs.
  assign o_hsync_pin = i_hsync_oe ? i_hsync_out : i_src_hsync;
  assign o_vsync_pin = i_vsync_oe ? i_vsync_out : i_src_vsync;
  // Comparator results follow the attached loads.
  assign o_dac_connected = i_loads;
endmodule : eicr_video_source
`default_nettype wire

/* testbench/eicr_regs_tb.sv */
// Self-checking bench for the input configuration register bank.
// Assumes the strobe register port and the video source model.
`timescale 1ns/1ns
`default_nettype none
module eicr_regs_tb;
  import eicr_pkg::*;
  logic i_clk, i_rst_b, i_reg_wr, i_reg_rd, i_vblank_update, rvalid, hd, bg, rate, orate, inv;
  logic master, behind, load, pol, pen, rgb, ycc, hoe, voe, hout, vout, hact, vact, emb, ibt;
  logic hold, crystal_osc_gain, hpin, vpin, src_h, src_v;
  logic [7:0] i_reg_addr, i_reg_wdata, rdata;
  logic [1:0] gout, goe, gpin, force_low;
  logic [2:0] steps, fmt;
  logic [3:0] loads, dacc;
  int fail_count, n_tests, i;
  eicr_regs u_eicr_regs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_gpio_pin(gpin), .i_hsync_pin(hpin), .i_vsync_pin(vpin),
    .i_int_hsync(src_h), .i_int_vsync(src_v),
    .i_embedded_hsync(!src_h), .i_embedded_vsync(!src_v),
    .i_vblank_update(i_vblank_update), .i_dac_connected(dacc), .o_hd_mode_select(hd),
    .o_bandgap_boost(bg), .o_in_clock_rate_sel(rate), .o_dual_edge_capture(),
    .o_clk_out_rate_sel(orate), .o_in_clock_invert(inv), .o_pll_master(master),
    .o_pll_div_force_one(), .o_clock_delay_behind(behind), .o_clock_delay_steps(steps),
    .o_black_level_load(load), .o_clk_out_polarity(pol), .o_clk_out_enable(pen),
    .o_gpio_out(gout), .o_gpio_oe(goe), .o_input_format_sel(fmt), .o_format_is_rgb(rgb),
    .o_format_is_ycrcb(ycc), .o_hsync_out(hout), .o_hsync_oe(hoe), .o_vsync_out(vout),
    .o_vsync_oe(voe), .o_hsync_active(hact), .o_vsync_active(vact),
    .o_sync_from_embedded(emb), .o_input_buffer_type(ibt), .o_dac_hold_constant(hold),
    .o_tv_sync_suppress(), .o_crystal_osc_gain_msb(crystal_osc_gain));
  eicr_video_source u_eicr_video_source (.i_gpio_out(gout), .i_gpio_oe(goe),
    .i_force_low(force_low), .i_hsync_out(hout), .i_hsync_oe(hoe), .i_vsync_out(vout),
    .i_vsync_oe(voe), .i_src_hsync(src_h), .i_src_vsync(src_v), .i_loads(loads),
    .o_gpio_pin(gpin), .o_hsync_pin(hpin), .o_vsync_pin(vpin), .o_dac_connected(dacc));
  // Clock at 25 MHz.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask : chk1
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  // One write strobe; the design takes it at the second edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask : wr
  // One read strobe, then a bounded wait for the valid pulse.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int k;
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) cyc(1);
    if (k == 4) begin
      fail_count++;
      $display("[ERR] %0t no read answer", $time);
      finish_test();
    end else begin
      chk(rdata, exp);
    end
  endtask : rd
  // Black level request pulse, then the load pulse one edge later.
  task automatic blk(input logic exp);
    @(posedge i_clk);
    i_vblank_update <= 1'b1;
    @(posedge i_clk);
    i_vblank_update <= 1'b0;
    #1;
    chk1(load, exp);
  endtask : blk
  // Hang guard.
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    finish_test();
  end
  // Main sequence.
  initial begin
    {i_rst_b, i_reg_wr, i_reg_rd, i_vblank_update, src_h, src_v} = 6'b0;
    {i_reg_addr, i_reg_wdata, force_low, loads} = '0;
    fail_count = 0;
    n_tests = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    cyc(6);
    rd(TV_STANDARD_OFS, 8'h02);
    rd(CLOCK_MODE_OFS, 8'h00);
    rd(INPUT_CLOCK_DELAY_OFS, 8'h48);
    rd(PIN_CONTROL_OFS, 8'hf2);
    rd(INPUT_FORMAT_OFS, 8'ha4);
    chk1(goe[0] | goe[1], 1'b0);
    chk({3'h0, ycc, ibt, hoe, crystal_osc_gain, hd}, 8'h1e);
    $display("test reset values done");
    wr(TV_STANDARD_OFS, 8'h81);
    chk({6'h0, bg, hd}, 8'h03);
    wr(CLOCK_MODE_OFS, 8'h0f);
    chk({4'h0, master, inv, orate, rate}, 8'h0f);
    wr(CLOCK_MODE_OFS, 8'h00);
    chk({4'h0, master, inv, orate, rate}, 8'h00);
    wr(INPUT_CLOCK_DELAY_OFS, 8'h07);
    chk({4'h0, behind, steps}, 8'h07);
    blk(1'b0);
    wr(INPUT_CLOCK_DELAY_OFS, 8'h4f);
    chk({4'h0, behind, steps}, 8'h0f);
    blk(1'b1);
    wr(8'h15, 8'hff);
    rd(8'h15, 8'h00);
    $display("test clock and delay done");
    wr(PIN_CONTROL_OFS, 8'h11);
    cyc(6);
    chk({2'h0, pol, pen, goe, gout}, 8'h2d);
    chk({6'h0, gpin}, 8'h01);
    wr(PIN_CONTROL_OFS, 8'h52);
    cyc(6);
    rd(PIN_CONTROL_OFS, 8'h52);
    force_low <= 2'b01;
    cyc(6);
    rd(PIN_CONTROL_OFS, 8'h42);
    $display("test pins done");
    for (i = 0; i < 8; i++) begin
      wr(INPUT_FORMAT_OFS, 8'(i));
      chk({2'h0, ibt, ycc, rgb, fmt}, {2'h0, 1'b0, i == 4, i <= 3, 3'(i)});
    end
    wr(INPUT_FORMAT_OFS, 8'h84);
    cyc(6);
    chk({3'h0, ibt, hoe, hact, vact, emb}, 8'h16);
    wr(INPUT_FORMAT_OFS, 8'h5c);
    cyc(6);
    chk({5'h0, hact, vact, emb}, 8'h07);
    wr(INPUT_FORMAT_OFS, 8'h43);
    cyc(6);
    chk1(emb, 1'b0);
    src_h <= 1'b1;
    wr(INPUT_FORMAT_OFS, 8'h24);
    cyc(3);
    chk({4'h0, hoe, voe, hout, hact}, 8'h0d);
    $display("test format and sync done");
    loads <= 4'b0101;
    wr(CONNECTION_DETECT_OFS, 8'h41);
    chk1(hold, 1'b1);
    cyc(3);
    chk1(hout, 1'b1);
    wr(CONNECTION_DETECT_OFS, 8'h40);
    chk1(hold, 1'b0);
    rd(CONNECTION_DETECT_OFS, 8'h4a);
    loads <= 4'b1111;
    wr(CONNECTION_DETECT_OFS, 8'h1e);
    cyc(4);
    rd(CONNECTION_DETECT_OFS, 8'h0a);
    chk1(crystal_osc_gain, 1'b0);
    $display("test load sense done");
    finish_test();
  end
endmodule : eicr_regs_tb
`default_nettype wire
